// [dv/tam_alarm_props.sv]
module tam_alarm_props (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// conversions and alarm
	input wire logic        res_valid,
	input wire logic        alarm_o,
	input wire logic        alarm_oe,
	input wire logic        irq,
	input wire logic        global_flag
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_od; !alarm_o; endproperty
	a_od: assert property (p_od) else $error("alarm data not low");
	property p_oe; alarm_oe |-> irq && global_flag; endproperty
	a_oe: assert property (p_oe) else $error("pin active without cause");
	property p_irq; irq |-> global_flag; endproperty
	a_irq: assert property (p_irq) else $error("irq without status");
	property p_rst;
		disable iff (1'b0) !aresetn |=> !global_flag && !alarm_oe && !s_axi_bvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("state kept over reset");
	property p_rise;
		$rose(global_flag) |-> $past(res_valid) || $past(s_axi_awvalid && s_axi_wvalid, 2);
	endproperty
	a_rise: assert property (p_rise) else $error("flag set without result");
	property p_fall;
		$fell(global_flag) |-> $past(res_valid) || $past(s_axi_arvalid && !s_axi_rvalid)
			|| $past(s_axi_awvalid && s_axi_wvalid) || $past(s_axi_awvalid && s_axi_wvalid, 2);
	endproperty
	a_fall: assert property (p_fall) else $error("flag dropped without cause");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer not held");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write answer not held");
endmodule // tam_alarm_props

bind tam_alarm tam_alarm_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.res_valid, .alarm_o, .alarm_oe, .irq, .global_flag);

// [dv/tam_host_model.sv]
module tam_host_model (
	// pin from the device
	input  wire logic alarm_o,
	input  wire logic alarm_oe,
	// level seen by the host
	output logic      alarm_pin_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-up when released
	assign alarm_pin_n = alarm_oe ? alarm_o : 1'b1;
endmodule // tam_host_model

// [dv/test_threshold_alarm_monitor.sv]
`define WAITN(c) \
	i = 0; \
	do begin \
		@(negedge aclk); \
		i++; \
	end while (!(c) && i < 50); \
	if (i >= 50) begin \
		n_fail++; \
		end_sim(); \
	end
`define CHK(a, e) \
	cmp_count++; \
	if ((a) !== (e)) begin \
		n_fail++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
	end

module test_threshold_alarm_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [2:0] c; logic [11:0] d; logic [10:0] s;} tam_row_t;
	logic        aclk = 0, aresetn = 0, res_valid = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rdat;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [2:0]  res_chan = 0;
	logic [11:0] res_data = 0;
	logic [1:0]  rrsp, brsp;
	wire  [31:0] s_axi_rdata;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         alarm_o, alarm_oe, irq, global_flag, alarm_pin_n;
	int          n_fail = 0, cmp_count = 0;
	tam_row_t    rows [14] = '{
		'{3'h0, 12'h101, 11'h001}, '{3'h0, 12'h100, 11'h000}, '{3'h0, 12'h00f, 11'h001},
		'{3'h0, 12'h010, 11'h000}, '{3'h4, 12'h201, 11'h010}, '{3'h4, 12'h180, 11'h010},
		'{3'h4, 12'h108, 11'h000}, '{3'h4, 12'h0ff, 11'h020}, '{3'h4, 12'h1f7, 11'h020},
		'{3'h4, 12'h1f8, 11'h000}, '{3'h6, 12'h4b1, 11'h400}, '{3'h6, 12'h471, 11'h400},
		'{3'h6, 12'h470, 11'h000}, '{3'h7, 12'hfff, 11'h000}};

	tam_alarm DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .res_valid, .res_chan, .res_data,
		.alarm_o, .alarm_oe, .irq, .global_flag);
	tam_host_model HOST (.alarm_o, .alarm_oe, .alarm_pin_n);

	always #50 aclk = ~aclk;

	task automatic end_sim();
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		`WAITN(s_axi_awready)
		@(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		`WAITN(s_axi_bvalid)
		brsp = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		@(negedge aclk);
	endtask

	task automatic rd(input logic [7:0] a);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		`WAITN(s_axi_arready)
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		`WAITN(s_axi_rvalid)
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		@(negedge aclk);
	endtask

	task automatic cv(input logic [2:0] c, input logic [11:0] d, input int n);
		repeat (n) begin
			@(posedge aclk);
			res_valid <= 1'b1;
			res_chan <= c;
			res_data <= d;
			@(posedge aclk);
			res_valid <= 1'b0;
		end
		@(negedge aclk);
	endtask

	initial begin
		int n;
		logic [2:0] c;
		logic [11:0] hi, inr;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h0c);
		`CHK(rdat, 32'h04c)
		wr(8'h40, 32'h100);
		wr(8'h60, 32'h010);
		wr(8'h50, 32'h200);
		wr(8'h70, 32'h100);
		wr(8'h90, 32'h01f);
		wr(8'h08, 32'h7ff);
		wr(8'h0c, 32'h003);
		`CHK(brsp, 2'h0)
		foreach (rows[j]) begin
			cv(rows[j].c, rows[j].d, 1);
			`CHK(alarm_pin_n, ~|rows[j].s)
			`CHK(irq, |rows[j].s)
			rd(8'h00);
			`CHK(rdat[10:0], rows[j].s)
		end
		// every filter count, analog then temperature
		for (int k = 0; k < 12; k++) begin
			c = (k < 8) ? 3'h0 : 3'h4;
			n = (k < 8) ? ((k == 0) ? 1 : (2 << k)) : (1 << (k - 8));
			hi = (k < 8) ? 12'h101 : 12'h201;
			inr = (k < 8) ? 12'h080 : 12'h108;
			wr(8'h0c, (k < 8) ? {27'h0, k[2:0], 2'b10} : {25'h0, k[1:0], 5'h02});
			if (n > 1) begin
				cv(c, hi, n - 1);
				cv(c, inr, 1);
			end
			cv(c, hi, n - 1);
			`CHK(global_flag, 1'b0)
			cv(c, hi, 1);
			`CHK(global_flag, 1'b1)
			cv(c, inr, 1);
			`CHK(global_flag, 1'b1)
			rd(8'h00);
			`CHK(rdat[10:0], (k < 8) ? 11'h001 : 11'h010)
			`CHK(global_flag, 1'b0)
		end
		wr(8'h0c, 32'h000);
		cv(3'h0, 12'h101, 1);
		`CHK({global_flag, irq, alarm_pin_n}, 3'b111)
		cv(3'h0, 12'h080, 1);
		wr(8'h04, 32'h001);
		`CHK(global_flag, 1'b0)
		wr(8'h08, 32'h000);
		cv(3'h0, 12'h101, 1);
		`CHK({global_flag, irq}, 2'b10)
		rd(8'h00);
		`CHK(global_flag, 1'b0)
		cv(3'h0, 12'h101, 1);
		`CHK(global_flag, 1'b1)
		wr(8'h10, 32'h001);
		rd(8'h0c);
		`CHK(rdat, 32'h04c)
		`CHK(global_flag, 1'b0)
		rd(8'hfc);
		`CHK({rrsp, rdat}, 34'h200000000)
		wr(8'hfc, 32'h0000_0000);
		`CHK(brsp, 2'h2)
		cv(3'h6, 12'h4b1, 1);
		`CHK(global_flag, 1'b1)
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`CHK({global_flag, alarm_pin_n}, 2'b01)
		end_sim();
	end
endmodule // test_threshold_alarm_monitor

// [verilog/tam_alarm.v]
// The address map and the AXI4-Lite register port were chosen for this implementation.
`include "tam_consts.vh"

module tam_alarm #(
	parameter ADDR_W = 8,
	parameter RES_W  = 12
) (
	// clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// axi4-lite write address and data
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	// axi4-lite write response
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	output reg  [1:0]        s_axi_bresp,
	// axi4-lite read
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	// conversion results from the sequencer
	input  wire              res_valid,
	input  wire [2:0]        res_chan,
	input  wire [RES_W-1:0]  res_data,
	// alarm pin and interrupt
	output wire              alarm_o,
	output wire              alarm_oe,
	output wire              irq,
	output wire              global_flag
);

	localparam NS = `TAM_NUM_SRC;
	localparam NC = `TAM_NUM_CHAN;

	// configuration
	reg  [RES_W-1:0] high_th [0:NC-1];
	reg  [RES_W-1:0] low_th  [0:NC-1];
	reg  [6:0]       hys     [0:NC-1];
	reg  [NS-1:0]    source_enable_bit;
	reg              latch_disable;
	reg              alarm_out_en;
	reg  [2:0]       analog_consec_count_sel;
	reg  [1:0]       temp_consec_count_sel;
	reg              soft_rst;

	// monitor state
	reg  [NS-1:0]    status;
	reg  [NS-1:0]    cond;
	reg  [8:0]       cnt [0:NS-1];
	reg  [NS-1:0]    next_cond;
	reg  [8:0]       next_cnt [0:NS-1];
	reg  [NS-1:0]    set_ev;
	reg  [NS-1:0]    clr_mask;

	// bus
	wire             wr_fire;
	wire             rd_fire;
	reg              wr_hit;
	reg  [31:0]      next_rdata;
	reg              rd_hit;
	wire [7:0]       waddr;
	wire [7:0]       raddr;
	wire [2:0]       wch;
	wire [2:0]       rch;
	integer          i;
	integer          j;
	integer          k;

	// source index to result channel
	function [2:0] chan_of;
		input integer s;
		begin
			if (s < 4)
				chan_of = s[2:0];
			else if (s == `TAM_SRC_OVERTEMP)
				chan_of = `TAM_CHAN_LOCAL;
			else
				chan_of = 3'h4 + s[3:1] - 3'h2;
		end
	endfunction

	// consecutive count needed before a source alarms
	function [8:0] need_n;
		input integer s;
		input [2:0]   asel;
		input [1:0]   tsel;
		begin
			if (s == `TAM_SRC_OVERTEMP)
				need_n = 9'h001;
			else if (s < 4)
				need_n = (asel == 3'h0) ? 9'h001 : (9'h002 << asel);
			else
				need_n = 9'h001 << tsel;
		end
	endfunction

	// ---------------- filtering and hysteresis ----------------
	reg  [7:0]  hw;
	reg  [13:0] r_ext;
	reg  [13:0] h_ext;
	reg  [13:0] l_ext;
	reg         viol;
	reg         relieved;
	reg  [2:0]  c;

	always @* begin
		hw = 8'h00;
		r_ext = 14'h0000;
		h_ext = 14'h0000;
		l_ext = 14'h0000;
		viol = 1'b0;
		relieved = 1'b0;
		c = 3'h0;
		set_ev = {NS{1'b0}};
		for (i = 0; i < NS; i = i + 1) begin
			next_cond[i] = cond[i];
			next_cnt[i] = cnt[i];
			c = chan_of(i);
			if (res_valid && res_chan == c) begin
				r_ext = {{(14-RES_W){1'b0}}, res_data};
				h_ext = {{(14-RES_W){1'b0}}, high_th[c]};
				l_ext = {{(14-RES_W){1'b0}}, low_th[c]};
				// temperature deadband in whole degrees, scaled to result codes
				if (i < 4)
					hw = {1'b0, hys[c]};
				else
					hw = {hys[c][4:0], 3'h0};
				// die over-temperature: local result against a fixed limit
				if (i == `TAM_SRC_OVERTEMP) begin
					h_ext = {{(14-RES_W){1'b0}}, `TAM_OVERTEMP_CODE};
					hw = `TAM_OVERTEMP_HYS;
					viol = r_ext > h_ext;
					relieved = r_ext + {6'h00, hw} <= h_ext;
				end else if (i < 4) begin
					viol = (r_ext > h_ext) || (r_ext < l_ext);
					relieved = (r_ext + {6'h00, hw} <= h_ext) && (r_ext >= l_ext + {6'h00, hw});
				end else if (i[0] == 1'b0) begin
					viol = r_ext > h_ext;
					relieved = r_ext + {6'h00, hw} <= h_ext;
				end else begin
					viol = r_ext < l_ext;
					relieved = r_ext >= l_ext + {6'h00, hw};
				end
				// count only while not yet alarmed
				if (viol) begin
					if (!cond[i]) begin
						if (cnt[i] + 9'h001 >= need_n(i, analog_consec_count_sel,
						                              temp_consec_count_sel)) begin
							next_cond[i] = 1'b1;
							next_cnt[i] = 9'h000;
						end else begin
							next_cnt[i] = cnt[i] + 9'h001;
						end
					end
				end else begin
					next_cnt[i] = 9'h000;
					if (cond[i] && relieved)
						next_cond[i] = 1'b0;
				end
				// an active condition re-marks its bit on every result
				set_ev[i] = next_cond[i];
			end
		end
	end

	// filters and conditions restart on either reset
	always @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			cond <= {NS{1'b0}};
			for (j = 0; j < NS; j = j + 1)
				cnt[j] <= 9'h000;
		end else begin
			cond <= next_cond;
			for (j = 0; j < NS; j = j + 1)
				cnt[j] <= next_cnt[j];
		end
	end

	// ---------------- status ----------------
	always @* begin
		clr_mask = {NS{1'b0}};
		if (rd_fire && raddr == `TAM_OFF_STATUS)
			clr_mask = {NS{1'b1}};
		if (wr_fire && waddr == `TAM_OFF_CLEAR && s_axi_wstrb[0])
			clr_mask = clr_mask | s_axi_wdata[NS-1:0];
	end

	// a new event wins over a read or clear in the same cycle
	always @(posedge aclk) begin
		if (!aresetn || soft_rst)
			status <= {NS{1'b0}};
		else if (latch_disable)
			status <= next_cond;
		else
			status <= (status & ~clr_mask) | set_ev;
	end

	// pin pulled low only with output enable and an enabled bit set
	assign global_flag = |status;
	assign irq = |(status & source_enable_bit);
	assign alarm_oe = alarm_out_en & irq;
	assign alarm_o = 1'b0;

	// ---------------- axi4-lite slave ----------------
	// word addressing; byte lanes below bit 2 ignored
	assign waddr = {s_axi_awaddr[7:2], 2'h0};
	assign raddr = {s_axi_araddr[7:2], 2'h0};
	assign wch = waddr[4:2];
	assign rch = raddr[4:2];
	// address and data taken together, one write outstanding
	assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign wr_fire = s_axi_awready;
	// one read outstanding
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;

	always @* begin
		wr_hit = (waddr == `TAM_OFF_CLEAR) || (waddr == `TAM_OFF_ENABLE) ||
		         (waddr == `TAM_OFF_CTRL) || (waddr == `TAM_OFF_SWRESET) ||
		         (((waddr[7:5] == `TAM_REG_HIGH) || (waddr[7:5] == `TAM_REG_LOW) ||
		           (waddr[7:5] == `TAM_REG_HYS)) && wch < NC);
	end

	// config writes need the low byte lane
	always @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			source_enable_bit <= `TAM_RST_ENABLE;
			latch_disable <= 1'b0;
			alarm_out_en <= 1'b0;
			analog_consec_count_sel <= `TAM_RST_ACNT;
			temp_consec_count_sel <= `TAM_RST_TCNT;
			for (k = 0; k < NC; k = k + 1) begin
				high_th[k] <= `TAM_RST_HIGH;
				low_th[k] <= `TAM_RST_LOW;
				hys[k] <= `TAM_RST_HYS;
			end
		end else if (wr_fire && s_axi_wstrb[0]) begin
			if (waddr == `TAM_OFF_ENABLE)
				source_enable_bit <= s_axi_wdata[NS-1:0];
			if (waddr == `TAM_OFF_CTRL) begin
				latch_disable <= s_axi_wdata[`TAM_CTRL_LATCH_DIS];
				alarm_out_en <= s_axi_wdata[`TAM_CTRL_OUT_EN];
				analog_consec_count_sel <= s_axi_wdata[`TAM_CTRL_ACNT_LO +: 3];
				temp_consec_count_sel <= s_axi_wdata[`TAM_CTRL_TCNT_LO +: 2];
			end
			if (wch < NC) begin
				if (waddr[7:5] == `TAM_REG_HIGH)
					high_th[wch] <= s_axi_wdata[RES_W-1:0];
				if (waddr[7:5] == `TAM_REG_LOW)
					low_th[wch] <= s_axi_wdata[RES_W-1:0];
				if (waddr[7:5] == `TAM_REG_HYS)
					hys[wch] <= (wch < 3'h4) ? s_axi_wdata[6:0] : {2'h0, s_axi_wdata[4:0]};
			end
		end
	end

	// software reset: one-cycle pulse after a write of any value
	always @(posedge aclk) begin
		if (!aresetn)
			soft_rst <= 1'b0;
		else
			soft_rst <= wr_fire && s_axi_wstrb[0] && waddr == `TAM_OFF_SWRESET;
	end

	// answer one cycle after the taking edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TAM_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `TAM_RESP_OKAY : `TAM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// unmapped reads answer zero with slave error
	always @* begin
		next_rdata = 32'h0000_0000;
		rd_hit = 1'b1;
		if (raddr == `TAM_OFF_STATUS)
			next_rdata[NS-1:0] = status;
		else if (raddr == `TAM_OFF_ENABLE)
			next_rdata[NS-1:0] = source_enable_bit;
		else if (raddr == `TAM_OFF_CTRL) begin
			next_rdata[`TAM_CTRL_LATCH_DIS] = latch_disable;
			next_rdata[`TAM_CTRL_OUT_EN] = alarm_out_en;
			next_rdata[`TAM_CTRL_ACNT_LO +: 3] = analog_consec_count_sel;
			next_rdata[`TAM_CTRL_TCNT_LO +: 2] = temp_consec_count_sel;
			next_rdata[`TAM_CTRL_GFLAG] = global_flag;
		end else if (raddr == `TAM_OFF_CLEAR || raddr == `TAM_OFF_SWRESET)
			next_rdata = 32'h0000_0000;
		else if (rch < NC && raddr[7:5] == `TAM_REG_HIGH)
			next_rdata[RES_W-1:0] = high_th[rch];
		else if (rch < NC && raddr[7:5] == `TAM_REG_LOW)
			next_rdata[RES_W-1:0] = low_th[rch];
		else if (rch < NC && raddr[7:5] == `TAM_REG_HYS)
			next_rdata[6:0] = hys[rch];
		else
			rd_hit = 1'b0;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TAM_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_hit ? `TAM_RESP_OKAY : `TAM_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // tam_alarm

// [verilog/tam_consts.vh]
`ifndef TAM_CONSTS_VH
`define TAM_CONSTS_VH

// register byte offsets
`define TAM_OFF_STATUS     8'h00
`define TAM_OFF_CLEAR      8'h04
`define TAM_OFF_ENABLE     8'h08
`define TAM_OFF_CTRL       8'h0c
`define TAM_OFF_SWRESET    8'h10
// window regions, one word per channel, address bits [7:5]
`define TAM_REG_HIGH       3'h2
`define TAM_REG_LOW        3'h3
`define TAM_REG_HYS        3'h4

// control register fields
`define TAM_CTRL_LATCH_DIS 0
`define TAM_CTRL_OUT_EN    1
`define TAM_CTRL_ACNT_LO   2
`define TAM_CTRL_TCNT_LO   5
`define TAM_CTRL_GFLAG     8

// reset values
`define TAM_RST_HIGH       12'hfff
`define TAM_RST_LOW        12'h000
`define TAM_RST_HYS        7'h00
`define TAM_RST_ENABLE     11'h000
`define TAM_RST_ACNT       3'h3
`define TAM_RST_TCNT       2'h2

// channel map and sources
`define TAM_NUM_CHAN       7
`define TAM_NUM_SRC        11
`define TAM_SRC_OVERTEMP   10
`define TAM_CHAN_LOCAL     3'h6

// temperature scale: 8 codes per degree; die over-temperature 150 C, 8 C deadband
`define TAM_TEMP_SHIFT     3
`define TAM_OVERTEMP_CODE  12'h4b0
`define TAM_OVERTEMP_HYS   8'h40

// axi responses
`define TAM_RESP_OKAY      2'h0
`define TAM_RESP_SLVERR    2'h2

`endif
